/* hdl/sarc_cfg.svh */
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH
`define SARC_CLK_NS        40
`define SARC_CONV_NS       1400
`define SARC_CONV_CYC      (`SARC_CONV_NS / `SARC_CLK_NS)
`define SARC_START_NS      40
`define SARC_START_CYC     ((`SARC_START_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_ACT_NS        600
`define SARC_ACT_CYC       (`SARC_ACT_NS / `SARC_CLK_NS)
`define SARC_QUIET_NS      125
`define SARC_QUIET_CYC     ((`SARC_QUIET_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_READ_CYC      6
`define SARC_INIT_READS    3
`define SARC_DATA_W        18
`define SARC_ONES          18'h3_ffff
`define SARC_ZERO          18'h0_0000
`define SARC_CNT_W         6
`define SARC_REG_CTRL      4'h0
`define SARC_REG_STAT      4'h1
`define SARC_REG_MASK      4'h2
`define SARC_REG_DATA      4'h3
`define SARC_REG_MODE      4'h4
`endif

/* hdl/sarc_pkg.sv */
`default_nettype none
`include "sarc_cfg.svh"
package sarc_pkg;
  typedef logic [`SARC_DATA_W-1:0] sarc_word_t;
  typedef logic [`SARC_CNT_W-1:0]  sarc_cnt_t;
  typedef enum logic [1:0] {SARC_SAMPLE, SARC_CONVERT} sarc_dev_e;
  typedef enum logic [2:0] {SARC_H_IDLE, SARC_H_INIT, SARC_H_START, SARC_H_WAIT,
                            SARC_H_QUIET, SARC_H_READ} sarc_host_e;
endpackage : sarc_pkg
`default_nettype wire

/* hdl/sarc_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarc_cfg.svh"
interface sarc_if;
  logic                    conversion_start_n;
  logic                    select_n;
  logic                    read_n;
  logic                    byte_lane_select;
  logic                    low_bits_select;
  logic                    busy;
  logic [`SARC_DATA_W-1:0] parallel_data_pins_out;
  logic [`SARC_DATA_W-1:0] parallel_data_pins_oe_n;
  modport dev  (input conversion_start_n, select_n, read_n, byte_lane_select,
                low_bits_select, output busy, parallel_data_pins_out,
                parallel_data_pins_oe_n);
  modport host (output conversion_start_n, select_n, read_n, byte_lane_select,
                low_bits_select, input busy, parallel_data_pins_out,
                parallel_data_pins_oe_n);
endinterface : sarc_if
`default_nettype wire

/* hdl/sarc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarc_cfg.svh"
module sarc_dev (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // link
  sarc_if.dev                          lnk,
  // analog side stand-in
  input  wire logic [`SARC_DATA_W-1:0] sample_code,
  output logic                         holding
);
  typedef struct packed {
    logic [1:0]         cs_s;
    logic [1:0]         rd_s, byte_s, low_s, cv_s;
    logic               cv_d, cs_d;
    sarc_pkg::sarc_dev_e st;
    sarc_pkg::sarc_cnt_t cnt;
    sarc_pkg::sarc_word_t code, res;
    logic               busy, hold;
    logic [`SARC_DATA_W-1:0] dout, oe_n;
  } sarc_dst_s;
  sarc_dst_s r, n;
  logic cv_fall, cs_fall;
  sarc_pkg::sarc_word_t lay;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.cs_s = {r.cs_s[0], lnk.select_n};
    n.rd_s = {r.rd_s[0], lnk.read_n};
    n.byte_s = {r.byte_s[0], lnk.byte_lane_select};
    n.low_s = {r.low_s[0], lnk.low_bits_select};
    n.cv_s = {r.cv_s[0], lnk.conversion_start_n};
    n.cv_d = r.cv_s[1];
    n.cs_d = r.cs_s[1];
    cv_fall = r.cv_d & ~r.cv_s[1];
    cs_fall = r.cs_d & ~r.cs_s[1];
    unique case (r.st)
      sarc_pkg::SARC_SAMPLE: begin
        if (cv_fall && !r.cs_s[1]) begin
          n.st = sarc_pkg::SARC_CONVERT;
          n.busy = 1'b1;
          n.hold = 1'b1;
          n.code = sample_code;
          n.cnt = '0;
        end else if (cs_fall) begin
          // a start edge in the same cycle as the select edge keeps the input held
          n.hold = 1'b0;
        end
      end
      sarc_pkg::SARC_CONVERT: begin
        n.cnt = r.cnt + 1'b1;
        if ((cv_fall && !r.cs_s[1]) || cs_fall) begin
          n.st = sarc_pkg::SARC_SAMPLE;
          n.busy = 1'b0;
          n.hold = 1'b0;
          n.res = `SARC_ZERO;
        end else if (r.cnt == `SARC_CNT_W'(`SARC_CONV_CYC - 1)) begin
          n.st = sarc_pkg::SARC_SAMPLE;
          n.busy = 1'b0;
          n.res = r.code;
          // select held high: sampling waits for select to fall
          n.hold = r.cs_s[1];
        end
      end
      default: n.st = sarc_pkg::SARC_SAMPLE;
    endcase
    lay = `SARC_ONES;
    unique case ({r.byte_s[1], r.low_s[1]})
      2'b00: lay = r.res;
      2'b01: lay[3:2] = r.res[1:0];
      2'b10: lay[17:10] = r.res[9:2];
      2'b11: lay[11:10] = r.res[1:0];
    endcase
    n.dout = lay;
    // one-cycle lag over pins is tolerated; host samples late
    n.oe_n = (!r.cs_s[1] && !r.rd_s[1]) ? `SARC_ZERO : `SARC_ONES;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '{cs_s: 2'h3, rd_s: 2'h3, byte_s: 2'h0, low_s: 2'h0,
             cv_s: 2'h3, cv_d: 1'b1, cs_d: 1'b1, st: sarc_pkg::SARC_SAMPLE,
             cnt: '0, code: '0, res: '0, busy: 1'b0, hold: 1'b0,
             dout: `SARC_ONES, oe_n: `SARC_ONES};
    end else begin
      r <= n;
    end
  end

  assign lnk.busy = r.busy;
  assign lnk.parallel_data_pins_out = r.dout;
  assign lnk.parallel_data_pins_oe_n = r.oe_n;
  assign holding = r.hold;
endmodule : sarc_dev
`default_nettype wire

/* hdl/sarc_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarc_cfg.svh"
module sarc_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  // link
  sarc_if.host             lnk
);
  typedef struct packed {
    logic [1:0] bz_s;
    logic       bz_d;
    logic [`SARC_DATA_W-1:0] pin_a, pin_b;
    sarc_pkg::sarc_host_e st;
    sarc_pkg::sarc_cnt_t cnt;
    logic [1:0] nrd;
    logic       cv_n, cs_n, rd_n, byt, low;
    logic       inited;
    sarc_pkg::sarc_word_t res;
    logic [1:0] stat, mask;
    logic       mode8;
    logic [31:0] rdata;
    logic       irq;
  } sarc_hst_s;
  sarc_hst_s r, n;
  logic [`SARC_DATA_W-1:0] bus;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.bz_s = {r.bz_s[0], lnk.busy};
    n.bz_d = r.bz_s[1];
    bus = lnk.parallel_data_pins_out;
    n.pin_a = bus;
    n.pin_b = r.pin_a;
    n.rdata = 32'h0000_0000;
    // clear first, so an event set further down in the same cycle wins
    if (wr && addr == `SARC_REG_STAT) n.stat = r.stat & ~wdata[1:0];
    if (wr && addr == `SARC_REG_MASK) n.mask = wdata[1:0];
    if (wr && addr == `SARC_REG_MODE) n.mode8 = wdata[0];
    if (rd) begin
      unique case (addr)
        `SARC_REG_CTRL: n.rdata = {29'h0, r.inited, r.st != sarc_pkg::SARC_H_IDLE, 1'b0};
        `SARC_REG_STAT: n.rdata = {30'h0, r.stat};
        `SARC_REG_MASK: n.rdata = {30'h0, r.mask};
        `SARC_REG_DATA: n.rdata = {14'h0, r.res};
        `SARC_REG_MODE: n.rdata = {31'h0, r.mode8};
        default:        n.rdata = 32'h0000_0000;
      endcase
    end
    n.cnt = r.cnt + 1'b1;
    unique case (r.st)
      sarc_pkg::SARC_H_IDLE: begin
        if (!r.inited) begin
          n.st = sarc_pkg::SARC_H_INIT; n.cnt = '0; n.nrd = '0;
        end else if (wr && addr == `SARC_REG_CTRL && wdata[0]) begin
          n.st = sarc_pkg::SARC_H_START; n.cnt = '0;
          n.cs_n = 1'b0; n.cv_n = 1'b0;
        end
      end
      sarc_pkg::SARC_H_INIT: begin
        n.rd_n = ~r.cnt[1];
        n.cs_n = 1'b0;
        if (r.cnt[1:0] == 2'h3) begin
          n.nrd = r.nrd + 1'b1;
          if (r.nrd == 2'(`SARC_INIT_READS - 1)) begin
            n.st = sarc_pkg::SARC_H_IDLE; n.inited = 1'b1;
            n.rd_n = 1'b1; n.cs_n = 1'b1;
          end
        end
      end
      sarc_pkg::SARC_H_START: begin
        // release start well inside the early conversion window
        if (r.cnt >= `SARC_CNT_W'(`SARC_START_CYC + 2)) begin
          n.cv_n = 1'b1; n.st = sarc_pkg::SARC_H_WAIT; n.cnt = '0;
        end
      end
      sarc_pkg::SARC_H_WAIT: begin
        if (r.bz_d && !r.bz_s[1]) begin
          n.st = sarc_pkg::SARC_H_READ; n.cnt = '0; n.nrd = '0;
          n.rd_n = 1'b0; n.byt = 1'b0; n.low = 1'b0;
          n.stat[0] = 1'b1;
        end else if (r.cnt == '1) begin
          n.st = sarc_pkg::SARC_H_IDLE; n.cs_n = 1'b1; n.stat[1] = 1'b1;
        end
      end
      sarc_pkg::SARC_H_READ: begin
        // sample after device sync plus bus sync delay
        if (r.cnt == `SARC_CNT_W'(`SARC_READ_CYC)) begin
          n.cnt = '0;
          n.nrd = r.nrd + 1'b1;
          if (!r.mode8) begin
            if (r.nrd == 2'h0) n.res = r.pin_b;
          end else begin
            unique case (r.nrd)
              2'h0: n.res[17:10] = r.pin_b[17:10];
              2'h1: n.res[9:2]  = r.pin_b[17:10];
              default: n.res[1:0] = r.pin_b[11:10];
            endcase
          end
          // byte lane stays high for both the middle and the last read
          n.byt = r.mode8;
          n.low = r.mode8 && r.nrd == 2'h1;
          if (!r.mode8 || r.nrd == 2'h2) begin
            n.rd_n = 1'b1; n.byt = 1'b0; n.low = 1'b0;
            n.st = sarc_pkg::SARC_H_QUIET;
          end
        end
      end
      sarc_pkg::SARC_H_QUIET: begin
        if (r.cnt >= `SARC_CNT_W'(`SARC_QUIET_CYC)) begin
          n.st = sarc_pkg::SARC_H_IDLE; n.cs_n = 1'b1;
        end
      end
      default: n.st = sarc_pkg::SARC_H_IDLE;
    endcase
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '{bz_s: 2'h0, bz_d: 1'b0, pin_a: '0, pin_b: '0,
             st: sarc_pkg::SARC_H_IDLE, cnt: '0, nrd: '0, cv_n: 1'b1, cs_n: 1'b1,
             rd_n: 1'b1, byt: 1'b0, low: 1'b0, inited: 1'b0, res: '0, stat: 2'h0,
             mask: 2'h0, mode8: 1'b0, rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign lnk.conversion_start_n = r.cv_n;
  assign lnk.select_n = r.cs_n;
  assign lnk.read_n = r.rd_n;
  assign lnk.byte_lane_select = r.byt;
  assign lnk.low_bits_select = r.low;
  assign rdata = r.rdata;
  assign irq = r.irq;
endmodule : sarc_host
`default_nettype wire

/* verif/sarc_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarc_cfg.svh"
module sarc_link_monitor (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst,
  // link
  input wire logic                    conversion_start_n,
  input wire logic                    select_n,
  input wire logic                    read_n,
  input wire logic                    byte_lane_select,
  input wire logic                    low_bits_select,
  input wire logic                    busy,
  input wire logic [`SARC_DATA_W-1:0] parallel_data_pins_out,
  input wire logic [`SARC_DATA_W-1:0] parallel_data_pins_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // pins follow the inputs through a two-stage sync, so look back four cycles
  logic [5:0] busy_cnt;
  logic [3:0] en_hist;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 6'h00;
      en_hist  <= 4'h0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
      en_hist  <= {en_hist[2:0], !select_n && !read_n};
    end
  end
  ////////////////////////////////////////
  property p_busy_rise;
    $fell(conversion_start_n) && !select_n && !busy |-> ##[1:5] busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");
  property p_busy_hold; $rose(busy) |-> busy[*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy short");
  property p_busy_len; $fell(busy) |-> busy_cnt == 6'h23; endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion length");
  property p_oe_whole;
    parallel_data_pins_oe_n == 18'h0_0000 || parallel_data_pins_oe_n == 18'h3_ffff; endproperty
  a_oe_whole: assert property (p_oe_whole) else $error("partial drive");
  property p_oe_cause; parallel_data_pins_oe_n != 18'h3_ffff |-> en_hist != 4'h0; endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("driven unasked");
  property p_oe_off; en_hist == 4'h0 |-> parallel_data_pins_oe_n == 18'h3_ffff; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
  property p_lay_10; !parallel_data_pins_oe_n[0] && byte_lane_select && !low_bits_select &&
    $past(byte_lane_select, 4) && !$past(low_bits_select, 4)
    |-> parallel_data_pins_out[9:0] == 10'h3ff; endproperty
  a_lay_10: assert property (p_lay_10) else $error("middle layout");
  property p_lay_11; !parallel_data_pins_oe_n[0] && byte_lane_select && low_bits_select &&
    $past(byte_lane_select, 4) && $past(low_bits_select, 4) |->
    parallel_data_pins_out[17:12] == 6'h3f && parallel_data_pins_out[9:0] == 10'h3ff; endproperty
  a_lay_11: assert property (p_lay_11) else $error("low layout");
endmodule : sarc_link_monitor
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarc_cfg.svh"
module tb_top;
  logic        mclk, rst, wr, rd, irq, hold_a, hold_b;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [17:0] code_a, code_b;
  int          miscompares, checks_done;
  sarc_if lnk();
  sarc_if lnk2();
  sarc_dev u_sarc_dev (.mclk(mclk), .rst(rst), .lnk(lnk), .sample_code(code_a), .holding(hold_a));
  sarc_dev u_sarc_dev_b (.mclk(mclk), .rst(rst), .lnk(lnk2), .sample_code(code_b),
    .holding(hold_b));
  sarc_host u_sarc_host (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .lnk(lnk));
  sarc_link_monitor u_sarc_link_monitor (.mclk(mclk), .rst(rst),
    .conversion_start_n(lnk.conversion_start_n), .select_n(lnk.select_n), .read_n(lnk.read_n),
    .byte_lane_select(lnk.byte_lane_select), .low_bits_select(lnk.low_bits_select),
    .busy(lnk.busy), .parallel_data_pins_out(lnk.parallel_data_pins_out),
    .parallel_data_pins_oe_n(lnk.parallel_data_pins_oe_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic ran_out;
    $display("BAD %0t wait ran out", $time);
    miscompares++;
    wrap_up();
  endtask : ran_out
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 got = rdata;
  endtask : bus
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    for (int i = 0; i < 60; i++) begin
      bus(a, 32'h0000_0000, 1'b0);
      if (got[b] === v) return;
    end
    ran_out();
  endtask : poll
  task automatic conv(input logic [17:0] c, input logic m, input logic k);
    code_a <= c;
    poll(`SARC_REG_CTRL, 1, 1'b0);
    bus(`SARC_REG_MODE, 32'(m), 1'b1);
    bus(`SARC_REG_MASK, 32'(k), 1'b1);
    bus(`SARC_REG_CTRL, 32'h0000_0001, 1'b1);
    poll(`SARC_REG_STAT, 0, 1'b1);
    chk(32'(irq), 32'(k));
    // done rises as the reads begin, so wait for the read sequence to end
    poll(`SARC_REG_CTRL, 1, 1'b0);
    chk(32'(hold_a), 32'h0000_0000);
    bus(`SARC_REG_DATA, 32'h0000_0000, 1'b0);
    chk(got, {14'h0, c});
    bus(`SARC_REG_STAT, 32'h0000_0001, 1'b1);
    bus(`SARC_REG_STAT, 32'h0000_0000, 1'b0);
    chk(got & 32'h0000_0001, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
  endtask : conv
  // second link: {select_n, start_n, read_n, byte, low}, driven straight by the bench
  task automatic l2(input logic [4:0] v, input int n);
    @(posedge mclk);
    {lnk2.select_n, lnk2.conversion_start_n, lnk2.read_n, lnk2.byte_lane_select,
      lnk2.low_bits_select} <= v;
    repeat (n) @(posedge mclk);
    #1;
  endtask : l2
  task automatic await(input logic lvl);
    for (int i = 0; i < 100; i++) begin
      @(posedge mclk);
      #1;
      if (lnk2.busy === lvl) return;
    end
    ran_out();
  endtask : await
  function automatic logic [17:0] lay(input logic [17:0] c, input logic [1:0] s);
    case (s)
      2'b00: return c;
      2'b01: return {14'h3fff, c[1:0], 2'b11};
      2'b10: return {c[9:2], 10'h3ff};
      default: return {6'h3f, c[1:0], 10'h3ff};
    endcase
  endfunction : lay
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    code_a = 18'h0_0000;
    miscompares = 0;
    checks_done = 0;
    {lnk2.select_n, lnk2.conversion_start_n, lnk2.read_n, lnk2.byte_lane_select,
      lnk2.low_bits_select} = 5'b11100;
    got = $urandom(32'h60f3);
    code_b = 18'($urandom());
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    poll(`SARC_REG_CTRL, 2, 1'b1);
    bus(4'hf, 32'h0000_0000, 1'b0);
    chk(got, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        conv(k == 0 ? 18'h3_ffff : k == 1 ? 18'h0_0000 : 18'($urandom()), m[0], k != 1);
      end
    end
    l2(5'b10100, 2);
    l2(5'b11100, 8);
    chk(32'(lnk2.busy), 32'h0000_0000);
    l2(5'b00100, 2);
    l2(5'b01100, 0);
    await(1'b1);
    chk(32'(hold_b), 32'h0000_0001);
    await(1'b0);
    l2(5'b01100, 2);
    chk(32'(hold_b), 32'h0000_0000);
    for (int j = 0; j < 4; j++) begin
      l2({3'b010, 2'(j)}, 6);
      chk(32'(lnk2.parallel_data_pins_out), 32'(lay(code_b, 2'(j))));
      chk(32'(lnk2.parallel_data_pins_oe_n), 32'h0000_0000);
    end
    // quiet spell before the next start edge keeps the sampling instant clean
    l2(5'b01100, 6);
    chk(32'(lnk2.parallel_data_pins_oe_n), 32'h0003_ffff);
    l2(5'b00100, 2);
    l2(5'b01100, 8);
    l2(5'b11100, 6);
    chk(32'(lnk2.busy), 32'h0000_0001);
    l2(5'b01100, 6);
    chk(32'(lnk2.busy), 32'h0000_0000);
    l2(5'b01000, 6);
    chk(32'(lnk2.parallel_data_pins_out), 32'h0000_0000);
    // select idles high at the end: sampling waits for the select edge
    l2(5'b01100, 2);
    l2(5'b00100, 2);
    l2(5'b01100, 4);
    l2(5'b11100, 0);
    await(1'b0);
    chk(32'(hold_b), 32'h0000_0001);
    l2(5'b01100, 6);
    chk(32'(hold_b), 32'h0000_0000);
    // a second start edge inside the conversion aborts it: busy drops and the result clears to zero
    l2(5'b00100, 2);
    l2(5'b01100, 8);
    chk(32'(lnk2.busy), 32'h0000_0001);
    l2(5'b00100, 2);
    l2(5'b01100, 6);
    chk(32'(lnk2.busy), 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
